// >>> pkg/timing_flag_pkg.sv
// package for the timing flag insertion block
`default_nettype none
package timing_flag_pkg;
  localparam int unsigned data_w = 32;
  localparam int unsigned word_w = 20;
  // register byte offsets
  localparam logic [11:0] ctrl_offset = 12'h000;
  localparam logic [11:0] status_offset = 12'h004;
  localparam logic [11:0] count_offset = 12'h008;
  // control field positions
  localparam int unsigned ctrl_detect_bit = 0;
  localparam int unsigned ctrl_ioproc_bit = 1;
  localparam int unsigned ctrl_test_bit = 2;
  localparam int unsigned ctrl_rate_lsb = 3;
  localparam logic [31:0] ctrl_reset = 32'h0000_0002;
  // status field positions
  localparam int unsigned stat_v_bit = 0;
  localparam int unsigned stat_f_bit = 1;
  localparam int unsigned stat_test_bit = 2;
  localparam int unsigned stat_rate_lsb = 3;
  // position of f and v in the timing reference xyz word (low ten bits)
  localparam int unsigned xyz_f_bit = 8;
  localparam int unsigned xyz_v_bit = 7;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  typedef enum logic [1:0] {
    rate_hd = 2'h0,
    rate_hd_1001 = 2'h1,
    rate_sd = 2'h2
  } rate_t;
  typedef struct packed {
    logic v;
    logic f;
  } flags_t;
  typedef struct packed {
    logic select;
    logic serial_out;
    logic serial_in;
    logic serial_clk;
  } shared_pins_t;
endpackage
`default_nettype wire

// >>> rtl/video_timing_flag_insert.sv
// timing flag insertion into timing reference words with axi4-lite control
`timescale 1ns/10ps
`default_nettype none
// Operation
// - v input sets v bit of each timing word when detect off, processing on
// - v input ignored while embedded timing detect is on
// - f input sets f bit of each timing word when detect off, processing on
// - f input ignored while embedded timing detect is on
// - test select high routes four shared pins to boundary scan
// - test select low routes four shared pins to serial host port
// - output rate is hd, hd divided by 1.001, or sd
module video_timing_flag_insert #(
  parameter int unsigned word_w = timing_flag_pkg::word_w
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [word_w-1:0] video_in,
  input wire logic trs_in,
  input wire timing_flag_pkg::flags_t flags_in,
  output logic [word_w-1:0] video_out,
  output logic trs_out,
  output timing_flag_pkg::rate_t rate_class_select,
  input wire timing_flag_pkg::shared_pins_t pins_in,
  output logic shared_serial_out_pin,
  output logic shared_serial_out_pin_oe,
  output timing_flag_pkg::shared_pins_t scan_pins,
  output timing_flag_pkg::shared_pins_t serial_host_port,
  input wire logic scan_serial_out,
  input wire logic host_serial_out
);
  logic [31:0] ctrl;
  logic [31:0] trs_count;
  logic embedded_timing_detect;
  logic io_processing_enable;
  logic test_select;
  logic insert_en;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [11:0] ar_addr;
  logic rate_ok;
  timing_flag_pkg::flags_t flags_q;

  assign embedded_timing_detect = ctrl[timing_flag_pkg::ctrl_detect_bit];
  assign io_processing_enable = ctrl[timing_flag_pkg::ctrl_ioproc_bit];
  assign test_select = ctrl[timing_flag_pkg::ctrl_test_bit];
  assign insert_en = !embedded_timing_detect && io_processing_enable;
  assign rate_class_select =
    timing_flag_pkg::rate_t'(ctrl[timing_flag_pkg::ctrl_rate_lsb +: 2]);

  // only the three line rates may be stored
  assign rate_ok = w_data[timing_flag_pkg::ctrl_rate_lsb +: 2] inside {
    timing_flag_pkg::rate_hd, timing_flag_pkg::rate_hd_1001,
    timing_flag_pkg::rate_sd};

  // write address and data may come in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr[11:0];
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (aw_held && w_held) begin
      w_held <= 1'b0;
    end
  end

  // control register write, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= timing_flag_pkg::ctrl_reset;
    end else if (aw_held && w_held &&
                 aw_addr == timing_flag_pkg::ctrl_offset) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i]) begin
          ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
        end
      end
      if (!rate_ok) begin
        ctrl[timing_flag_pkg::ctrl_rate_lsb +: 2] <=
          ctrl[timing_flag_pkg::ctrl_rate_lsb +: 2];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= timing_flag_pkg::resp_okay;
    end else if (aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr == timing_flag_pkg::ctrl_offset) ?
        timing_flag_pkg::resp_okay : timing_flag_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_addr = s_axi_araddr[11:0];

  always_comb begin
    next_rdata = '0;
    next_rresp = timing_flag_pkg::resp_okay;
    case (ar_addr)
      timing_flag_pkg::ctrl_offset: begin
        next_rdata = ctrl;
      end
      timing_flag_pkg::status_offset: begin
        next_rdata[timing_flag_pkg::stat_v_bit] = flags_q.v;
        next_rdata[timing_flag_pkg::stat_f_bit] = flags_q.f;
        next_rdata[timing_flag_pkg::stat_test_bit] = test_select;
        next_rdata[timing_flag_pkg::stat_rate_lsb +: 2] = rate_class_select;
      end
      timing_flag_pkg::count_offset: begin
        next_rdata = trs_count;
      end
      default: begin
        next_rresp = timing_flag_pkg::resp_slverr;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= timing_flag_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // flags taken on the same edge as their word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_in;
    end
  end

  // video pipeline, one stage, flags overwrite timing word bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      video_out <= '0;
      trs_out <= 1'b0;
    end else begin
      video_out <= video_in;
      trs_out <= trs_in;
      if (trs_in && insert_en) begin
        video_out[timing_flag_pkg::xyz_v_bit] <= flags_in.v;
        video_out[timing_flag_pkg::xyz_f_bit] <= flags_in.f;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trs_count <= '0;
    end else if (trs_in) begin
      trs_count <= trs_count + 32'h0000_0001;
    end
  end

  // shared pin steering
  always_comb begin
    scan_pins = '0;
    serial_host_port = '0;
    if (test_select) begin
      scan_pins = pins_in;
      shared_serial_out_pin = scan_serial_out;
    end else begin
      serial_host_port = pins_in;
      shared_serial_out_pin = host_serial_out;
    end
  end
  assign shared_serial_out_pin_oe = 1'b1;
endmodule
`default_nettype wire

// >>> test/video_timing_flag_insert_asserts.sv
// checker for the timing flag insertion block
`timescale 1ns/10ps
`default_nettype none
module video_timing_flag_insert_asserts #(
  parameter int unsigned word_w = timing_flag_pkg::word_w
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [word_w-1:0] video_in,
  input wire logic trs_in,
  input wire logic [word_w-1:0] video_out,
  input wire logic trs_out,
  input wire timing_flag_pkg::rate_t rate_class_select,
  input wire timing_flag_pkg::shared_pins_t pins_in,
  input wire logic shared_serial_out_pin,
  input wire logic shared_serial_out_pin_oe,
  input wire timing_flag_pkg::shared_pins_t scan_pins,
  input wire timing_flag_pkg::shared_pins_t serial_host_port,
  input wire logic scan_serial_out,
  input wire logic host_serial_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence trs_word;
    $past(aresetn) && $past(trs_in);
  endsequence
  chk_trs_delay: assert property ($past(aresetn) |-> trs_out == $past(trs_in))
    else $error("trs_out not one cycle after trs_in");
  chk_word_pass: assert property ($past(aresetn) && !$past(trs_in) |->
    video_out == $past(video_in)) else $error("plain word altered");
  chk_word_rest: assert property (trs_word |->
    video_out[word_w-1:9] == $past(video_in[word_w-1:9])
    && video_out[6:0] == $past(video_in[6:0])) else $error("trs word altered");
  chk_pins_split: assert property (scan_pins == 4'h0 ||
    serial_host_port == 4'h0) else $error("pins on both sides");
  chk_scan_route: assert property (scan_pins != 4'h0 |-> scan_pins == pins_in
    && shared_serial_out_pin == scan_serial_out) else $error("scan route");
  chk_host_route: assert property (serial_host_port != 4'h0 |->
    serial_host_port == pins_in && shared_serial_out_pin == host_serial_out)
    else $error("host route");
  chk_rate_legal: assert property (rate_class_select != 2'h3)
    else $error("illegal rate");
  chk_out_driven: assert property (shared_serial_out_pin_oe)
    else $error("serial out not driven");
endmodule
`default_nettype wire

// >>> test/video_source_model.sv
// parallel video source driving words and timing flags
`timescale 1ns/10ps
`default_nettype none
module video_source_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic v_state,
  input wire logic f_state,
  output logic [19:0] video_in,
  output logic trs_in,
  output timing_flag_pkg::flags_t flags_in
);
  logic [7:0] cnt;
  always_ff @(posedge aclk) begin
    cnt <= aresetn ? cnt + 8'h01 : 8'h00;
    video_in <= aresetn ? {cnt[3:0], cnt, ~cnt} : 20'h00000;
    trs_in <= aresetn && cnt[1:0] == 2'h3;
    flags_in <= aresetn ? {v_state, f_state} : 2'b00;
  end
endmodule
`default_nettype wire

// >>> test/tb_video_timing_flag_insert.sv
// testbench for the timing flag insertion block
`timescale 1ns/10ps
`default_nettype none
module tb_video_timing_flag_insert;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, pt;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, trs_in;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, trs_out, v_state, f_state;
  logic shared_serial_out_pin, shared_serial_out_pin_oe;
  logic scan_serial_out, host_serial_out;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [19:0] video_in, video_out, pv;
  timing_flag_pkg::flags_t flags_in, pf;
  timing_flag_pkg::rate_t rate_class_select;
  timing_flag_pkg::shared_pins_t pins_in, scan_pins, serial_host_port;
  int err_total, compares, tc;
  video_timing_flag_insert video_timing_flag_insert_i (.*);
  video_source_model video_source_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    pv <= video_in;
    pt <= trs_in;
    pf <= flags_in;
    tc <= aresetn ? tc + trs_in : 0;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    if (n >= 50) begin
      err_total++;
      wrap_up();
    end
    chk(s_axi_bresp, r);
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 50);
    if (n >= 50) begin
      err_total++;
      wrap_up();
    end
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask
  task automatic flag_run(input logic [31:0] c, input logic ins);
    logic [19:0] e;
    axi_wr(12'h000, c, 2'h0);
    for (int k = 0; k < 32; k++) begin
      if (k % 8 == 0) {v_state, f_state} <= k[4:3];
      @(negedge aclk);
      e = (pt && ins) ? {pv[19:9], pf.f, pf.v, pv[6:0]} : pv;
      chk({12'h0, video_out}, {12'h0, e});
      @(posedge aclk);
    end
  endtask
  task automatic pin_run(input logic [1:0] rt, input logic t);
    axi_wr(12'h000, {27'h0, rt, t, 2'b10}, 2'h0);
    pins_in <= 4'ha;
    scan_serial_out <= 1'b1;
    host_serial_out <= 1'b0;
    @(negedge aclk);
    chk(scan_pins, t ? 4'ha : 4'h0);
    chk(serial_host_port, t ? 4'h0 : 4'ha);
    chk(shared_serial_out_pin, t);
    chk(rate_class_select, rt);
    @(posedge aclk);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {v_state, f_state, scan_serial_out, host_serial_out} = 4'h0;
    pins_in = 4'h0;
    err_total = 0;
    compares = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(12'h000, timing_flag_pkg::ctrl_reset, 2'h0);
    axi_rd(12'h00c, 32'h0, timing_flag_pkg::resp_slverr);
    axi_wr(12'h008, 32'h5, timing_flag_pkg::resp_slverr);
    flag_run(32'h2, 1'b1);
    flag_run(32'h3, 1'b0);
    flag_run(32'h0, 1'b0);
    for (int i = 0; i < 6; i++) pin_run(i[2:1], i[0]);
    axi_wr(12'h000, 32'h0000_001a, 2'h0);
    chk(rate_class_select, 2'h2);
    s_axi_wstrb <= 4'h2;
    axi_wr(12'h000, 32'hffff_ff00, 2'h0);
    s_axi_wstrb <= 4'hf;
    axi_rd(12'h000, 32'h0000_ff12, 2'h0);
    axi_rd(12'h004, 32'h0000_0013, 2'h0);
    axi_rd(12'h008, tc + trs_in, 2'h0);
    wrap_up();
  end
endmodule
bind video_timing_flag_insert video_timing_flag_insert_asserts #(
  .word_w(word_w)) video_timing_flag_insert_asserts_i (.*);
`default_nettype wire
